/* File: core/io_port_uart_serial_flash.sv */
// i/o port block: holding fifo and the serial, strobe and status register top
`timescale 1ns/1ns

// ==========================================================
// holding fifo with valid and ready on both sides
module io_port_hold_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_type;

  fifo_state_type st;
  fifo_state_type next_st;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign in_ready = (st.count != FULL);
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update, flush drops everything held
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = (st.wr_ptr == LAST) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == LAST) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    if (flush) begin
      next_st.wr_ptr = '0;
      next_st.rd_ptr = '0;
      next_st.count = '0;
    end
  end

  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : io_port_hold_fifo

// ==========================================================
module io_port_uart_serial_flash
  import io_port_pkg::*;
#(
  parameter int HOLD_WORDS = io_port_pkg::HOLD_DEPTH
) (
  // clock and power-on reset
  input wire logic clock,
  input wire logic arst_n,
  // ordinary processor reset, does not touch the serial logic
  input wire logic cpu_reset_n,
  // register port
  input wire logic [7:0] periph_addr,
  input wire logic [3:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [io_port_pkg::WORD_WIDTH-1:0] reg_wdata,
  output logic [io_port_pkg::WORD_WIDTH-1:0] reg_rdata,
  // status sources and peek capture
  input wire logic [io_port_pkg::SPEED_WIDTH-1:0] speed_code,
  input wire logic mapper_enabled,
  input wire logic peek_capture,
  input wire logic [io_port_pkg::WORD_WIDTH-1:0] peek_value,
  // parallel strobe
  output logic parallel_pulse,
  // asynchronous serial pins
  output logic uart_tx,
  input wire logic uart_rx,
  // serial flash pins
  output logic flash_sck,
  output logic flash_do,
  input wire logic flash_di,
  output logic flash_wp_n,
  output logic flash_ce_n
);
  import io_port_pkg::*;

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic di_meta;
    logic di_sync;
    logic cpu_meta;
    logic cpu_sync;
    logic strobe;
    logic [WORD_WIDTH-1:0] peek;
    logic [WORD_WIDTH-1:0] rdata;
    logic flash_mode;
    logic wp_n;
    logic ce_n;
    logic [RATE_WIDTH-1:0] divisor;
    logic [RATE_WIDTH-1:0] baud_cnt;
    tx_state_type tx_state;
    logic [BYTE_WIDTH-1:0] tx_shift;
    logic [3:0] tx_bits;
    logic line_tx;
    logic line_do;
    logic line_sck;
    rx_state_type rx_state;
    logic [RATE_WIDTH-1:0] rx_cnt;
    logic [BYTE_WIDTH-1:0] rx_shift;
    logic [3:0] rx_bits;
    logic overrun;
  } state_type;

  // serial part back to its idle values, other fields kept
  function automatic state_type serial_init(input state_type s);
    state_type r;
    r = s;
    r.flash_mode = 1'b0;
    r.wp_n = 1'b1;
    r.ce_n = 1'b1;
    r.divisor = RATE_RESET;
    r.baud_cnt = RATE_RESET;
    r.tx_state = TX_IDLE;
    r.tx_shift = '0;
    r.tx_bits = '0;
    r.line_tx = 1'b1;
    r.line_do = 1'b0;
    r.line_sck = 1'b0;
    // rx sync at idle level, no false start
    r.rx_meta = 1'b1;
    r.rx_sync = 1'b1;
    r.rx_state = RX_IDLE;
    r.rx_cnt = '0;
    r.rx_shift = '0;
    r.rx_bits = '0;
    r.overrun = 1'b0;
    return r;
  endfunction : serial_init

  // register decode shared by reads and writes
  function automatic logic reg_hit(input logic [7:0] sel, input logic [3:0] a,
                                   input logic [3:0] ofs);
    return (sel == PERIPH_SELECT) && (a == ofs);
  endfunction : reg_hit

  // ==========================================================
  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // holding buffers
  state_type st;
  state_type next_st;
  logic serial_clear;
  logic tx_push;
  logic tx_ready;
  logic tx_avail;
  logic tx_take;
  logic [BYTE_WIDTH-1:0] tx_byte;
  logic rx_push;
  logic rx_ready;
  logic rx_held;
  logic rx_pop;
  logic [BYTE_WIDTH-1:0] rx_push_byte;
  logic [BYTE_WIDTH-1:0] rx_byte;
  logic tick;

  io_port_hold_fifo #(.WIDTH(BYTE_WIDTH), .DEPTH(HOLD_WORDS)) tx_hold (
    .clock(clock),
    .reset_n(rst_n),
    .flush(serial_clear),
    .in_valid(tx_push),
    .in_ready(tx_ready),
    .in_data(reg_wdata[BYTE_WIDTH-1:0]),
    .out_valid(tx_avail),
    .out_ready(tx_take),
    .out_data(tx_byte)
  );

  io_port_hold_fifo #(.WIDTH(BYTE_WIDTH), .DEPTH(HOLD_WORDS)) rx_hold (
    .clock(clock),
    .reset_n(rst_n),
    .flush(serial_clear),
    .in_valid(rx_push),
    .in_ready(rx_ready),
    .in_data(rx_push_byte),
    .out_valid(rx_held),
    .out_ready(rx_pop),
    .out_data(rx_byte)
  );

  // master reset command, writing zero does nothing
  assign serial_clear = reg_write && reg_hit(periph_addr, reg_addr, OFS_MASTER_RESET)
                        && reg_wdata[BIT_RESET_CMD];
  // data write queues a byte; a write while full is dropped
  assign tx_push = reg_write && reg_hit(periph_addr, reg_addr, OFS_DATA) && !serial_clear;
  assign rx_pop = reg_read && reg_hit(periph_addr, reg_addr, OFS_DATA);
  // engine takes the next byte only when idle
  assign tx_take = (st.tx_state == TX_IDLE) && tx_avail && !serial_clear;
  // one bit-time enable per divider expiry
  assign tick = (st.baud_cnt == '0);

  // ==========================================================
  // registers, shift engine and receiver
  always_comb begin
    next_st = st;
    rx_push = 1'b0;
    rx_push_byte = st.rx_shift;
    // pin inputs pass two flip-flops before use
    next_st.rx_meta = uart_rx;
    next_st.rx_sync = st.rx_meta;
    next_st.di_meta = flash_di;
    next_st.di_sync = st.di_meta;
    next_st.cpu_meta = cpu_reset_n;
    next_st.cpu_sync = st.cpu_meta;

    // peek value held until the next capture or a processor reset
    if (peek_capture) begin
      next_st.peek = peek_value;
    end

    // divider reload on expiry, restart when a frame begins
    if (tick || tx_take) begin
      next_st.baud_cnt = st.divisor;
    end else begin
      next_st.baud_cnt = st.baud_cnt - 1'b1;
    end

    // transmit and flash shifting
    case (st.tx_state)
      TX_IDLE: begin
        if (tx_take) begin
          next_st.tx_shift = tx_byte;
          next_st.tx_bits = '0;
          // flash shifts msb first, uart lsb first
          if (st.flash_mode) begin
            next_st.line_do = tx_byte[BYTE_WIDTH-1];
            next_st.line_sck = 1'b0;
            next_st.tx_state = TX_CLOCK;
          end else begin
            next_st.line_tx = 1'b0;
            next_st.tx_state = TX_START;
          end
        end
      end
      TX_START: begin
        if (tick) begin
          next_st.line_tx = st.tx_shift[0];
          next_st.tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tick) begin
          next_st.tx_bits = st.tx_bits + 1'b1;
          next_st.tx_shift = {1'b0, st.tx_shift[BYTE_WIDTH-1:1]};
          if (st.tx_bits == DATA_BITS - 1'b1) begin
            next_st.line_tx = 1'b1;
            next_st.tx_bits = '0;
            next_st.tx_state = TX_STOP;
          end else begin
            next_st.line_tx = st.tx_shift[1];
          end
        end
      end
      TX_STOP: begin
        // two stop bit-times before going idle
        if (tick) begin
          next_st.tx_bits = st.tx_bits + 1'b1;
          if (st.tx_bits == STOP_BITS - 1'b1) begin
            next_st.tx_state = TX_IDLE;
          end
        end
      end
      TX_CLOCK: begin
        // flash clock toggles per tick, reusing the rx shifter
        if (tick) begin
          next_st.line_sck = !st.line_sck;
          next_st.tx_bits = st.tx_bits + 1'b1;
          if (!st.line_sck) begin
            next_st.rx_shift = {st.rx_shift[BYTE_WIDTH-2:0], st.di_sync};
          end else begin
            next_st.tx_shift = {st.tx_shift[BYTE_WIDTH-2:0], 1'b0};
            next_st.line_do = st.tx_shift[BYTE_WIDTH-2];
          end
          // idle once bit 0 has been clocked out
          if (st.tx_bits == FLASH_EDGES) begin
            next_st.tx_state = TX_IDLE;
            rx_push = 1'b1;
          end
        end
      end
      default: begin
        next_st.tx_state = TX_IDLE;
      end
    endcase

    // uart receiver, mid-bit sampling on its own timer
    if (st.rx_cnt != '0) begin
      next_st.rx_cnt = st.rx_cnt - 1'b1;
    end
    case (st.rx_state)
      RX_IDLE: begin
        if (!st.flash_mode && !st.rx_sync) begin
          next_st.rx_cnt = {1'b0, st.divisor[RATE_WIDTH-1:1]};
          next_st.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (st.rx_cnt == '0) begin
          next_st.rx_cnt = st.divisor;
          next_st.rx_bits = '0;
          // a high line here was only a glitch
          next_st.rx_state = st.rx_sync ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (st.rx_cnt == '0) begin
          next_st.rx_cnt = st.divisor;
          next_st.rx_shift = {st.rx_sync, st.rx_shift[BYTE_WIDTH-1:1]};
          next_st.rx_bits = st.rx_bits + 1'b1;
          if (st.rx_bits == DATA_BITS - 1'b1) begin
            next_st.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (st.rx_cnt == '0) begin
          // bytes with a bad stop bit are dropped
          rx_push = st.rx_sync;
          next_st.rx_state = RX_IDLE;
        end
      end
      default: begin
        next_st.rx_state = RX_IDLE;
      end
    endcase

    // overrun: a new overrun wins over the clearing read
    if (rx_pop) begin
      next_st.overrun = 1'b0;
    end
    if (rx_push && !rx_ready) begin
      next_st.overrun = 1'b1;
    end

    // register writes through the one select address
    if (reg_write && reg_hit(periph_addr, reg_addr, OFS_CONTROL)) begin
      next_st.flash_mode = reg_wdata[BIT_MODE];
      next_st.ce_n = !reg_wdata[BIT_CE];
      next_st.wp_n = !reg_wdata[BIT_WP];
    end
    if (reg_write && reg_hit(periph_addr, reg_addr, OFS_RATE)) begin
      // divisor from the low twelve bits
      next_st.divisor = reg_wdata[RATE_WIDTH-1:0];
    end
    if (reg_write && reg_hit(periph_addr, reg_addr, OFS_STROBE)) begin
      next_st.strobe = !st.strobe;
    end

    // register reads, the answer is held until the next read
    if (reg_read) begin
      next_st.rdata = '0;
      if (periph_addr == PERIPH_SELECT) begin
        case (reg_addr)
          OFS_DATA: begin
            // received byte in the low bits
            next_st.rdata[BYTE_WIDTH-1:0] = rx_byte;
          end
          OFS_RX_STATUS: begin
            next_st.rdata[BIT_HELD] = rx_held;
            next_st.rdata[BIT_OVERRUN] = st.overrun;
          end
          OFS_TX_STATUS: begin
            next_st.rdata[BIT_TX_IDLE] = (st.tx_state == TX_IDLE);
            next_st.rdata[BIT_TX_EMPTY] = !tx_avail;
          end
          OFS_SPEED: begin
            next_st.rdata[SPEED_WIDTH-1:0] = speed_code;
          end
          OFS_MAPPER: begin
            next_st.rdata[BIT_MAPPER_ON] = mapper_enabled;
          end
          OFS_PEEK_DATA: begin
            next_st.rdata = st.peek;
          end
          default: begin
            // write-only and unused offsets read as zero
            next_st.rdata = '0;
          end
        endcase
      end
    end

    // processor reset clears only the strobe and peek latch
    if (!st.cpu_sync) begin
      next_st.strobe = 1'b0;
      next_st.peek = '0;
    end
    // serial logic back to idle, overrides any write above
    if (serial_clear) begin
      next_st = serial_init(next_st);
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= serial_init(state_type'('0));
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  assign reg_rdata = st.rdata;
  assign parallel_pulse = st.strobe;
  assign uart_tx = st.line_tx;
  assign flash_sck = st.line_sck;
  assign flash_do = st.line_do;
  assign flash_wp_n = st.wp_n;
  assign flash_ce_n = st.ce_n;
endmodule : io_port_uart_serial_flash

/* File: core/io_port_pkg.sv */
// constants, register map and state types of the on-chip i/o port block
package io_port_pkg;

  // ==========================================================
  // peripheral selection and register offsets
  localparam logic [7:0] PERIPH_SELECT = 8'hf0;
  localparam logic [3:0] OFS_PEEK_DATA = 4'h2;
  localparam logic [3:0] OFS_SPEED = 4'h4;
  localparam logic [3:0] OFS_MAPPER = 4'h6;
  localparam logic [3:0] OFS_STROBE = 4'h8;
  localparam logic [3:0] OFS_MASTER_RESET = 4'ha;
  localparam logic [3:0] OFS_CONTROL = 4'hb;
  localparam logic [3:0] OFS_RATE = 4'hc;
  localparam logic [3:0] OFS_TX_STATUS = 4'hd;
  localparam logic [3:0] OFS_RX_STATUS = 4'he;
  localparam logic [3:0] OFS_DATA = 4'hf;

  // ==========================================================
  // field positions
  localparam int BIT_MODE = 0;
  localparam int BIT_CE = 4;
  localparam int BIT_WP = 8;
  localparam int BIT_RESET_CMD = 0;
  localparam int BIT_HELD = 0;
  localparam int BIT_OVERRUN = 4;
  localparam int BIT_TX_EMPTY = 0;
  localparam int BIT_TX_IDLE = 4;
  localparam int BIT_MAPPER_ON = 0;
  localparam int RATE_WIDTH = 12;
  localparam int SPEED_WIDTH = 3;
  localparam int BYTE_WIDTH = 8;
  localparam int WORD_WIDTH = 16;

  // ==========================================================
  // reset values and frame counts
  localparam logic [11:0] RATE_RESET = 12'h000;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] STOP_BITS = 4'h2;
  localparam logic [3:0] FLASH_EDGES = 4'hf;
  localparam int HOLD_DEPTH = 1;

  // ==========================================================
  // engine states
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_CLOCK} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

endpackage : io_port_pkg

/* File: testbench/io_port_checker_sva.sv */
// assertion checker bound to the i/o port block top
`timescale 1ns/1ns
module io_port_checker (
  // clock and resets
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cpu_reset_n,
  // register port
  input wire logic [7:0] periph_addr,
  input wire logic [3:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // status sources and peek capture
  input wire logic [2:0] speed_code,
  input wire logic mapper_enabled,
  input wire logic peek_capture,
  input wire logic [15:0] peek_value,
  // pins
  input wire logic parallel_pulse,
  input wire logic uart_tx,
  input wire logic flash_sck,
  input wire logic flash_wp_n,
  input wire logic flash_ce_n
);
  import io_port_pkg::*;
  logic [15:0] wr_hit, rd_hit, peek_last;
  logic peek_seen;
  // one-hot decode of selected accesses
  assign wr_hit = (periph_addr == PERIPH_SELECT && reg_write) ? 16'h0001 << reg_addr : 16'h0000;
  assign rd_hit = (periph_addr == PERIPH_SELECT && reg_read) ? 16'h0001 << reg_addr : 16'h0000;
  // reference peek latch, forgotten while the processor reset is low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      peek_seen <= 1'b0;
      peek_last <= 16'h0000;
    end else if (!cpu_reset_n) begin
      peek_seen <= 1'b0;
    end else if (peek_capture) begin
      peek_seen <= 1'b1;
      peek_last <= peek_value;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // ======
  // strobe flips
  AST_STROBE_FLIP: assert property (
    cpu_reset_n [*4] ##0 wr_hit[OFS_STROBE] |=> parallel_pulse != $past(parallel_pulse))
    else $error("strobe did not flip after its write");
  AST_DATA_UPPER: assert property (
    rd_hit[OFS_DATA] |=> reg_rdata[15:8] == 8'h00)
    else $error("data read upper byte not zero");
  AST_RX_SPARE: assert property (
    rd_hit[OFS_RX_STATUS] |=> (reg_rdata & 16'hffee) == 16'h0000)
    else $error("rx status spare bits set");
  AST_TX_SPARE: assert property (
    rd_hit[OFS_TX_STATUS] |=> (reg_rdata & 16'hffee) == 16'h0000)
    else $error("tx status spare bits set");
  AST_RATE_HIDDEN: assert property (
    rd_hit[OFS_RATE] |=> reg_rdata == 16'h0000)
    else $error("rate register read not zero");
  AST_SPEED_CODE: assert property (
    rd_hit[OFS_SPEED] |=> reg_rdata == {13'h0000, $past(speed_code)})
    else $error("speed status differs from speed input");
  AST_MAPPER_BIT: assert property (
    rd_hit[OFS_MAPPER] |=> reg_rdata == {15'h0000, $past(mapper_enabled)})
    else $error("mapper status differs from mapper input");
  AST_PEEK_HOLD: assert property (
    rd_hit[OFS_PEEK_DATA] && peek_seen && !peek_capture |=> reg_rdata == $past(peek_last))
    else $error("peek data lost its captured value");
  AST_WP_LEVEL: assert property (
    wr_hit[OFS_CONTROL] ##1 wr_hit == 16'h0000 |=> flash_wp_n == !$past(reg_wdata[BIT_WP], 2))
    else $error("write-protect pin does not follow control");
  AST_CE_LEVEL: assert property (
    wr_hit[OFS_CONTROL] ##1 wr_hit == 16'h0000 |=> flash_ce_n == !$past(reg_wdata[BIT_CE], 2))
    else $error("chip-enable pin does not follow control");
  AST_MASTER_RESET: assert property (
    wr_hit[OFS_MASTER_RESET] && reg_wdata[BIT_RESET_CMD]
    |-> ##2 (flash_wp_n && flash_ce_n && uart_tx && !flash_sck))
    else $error("master reset left serial pins active");
  // main scenarios reached
  cover property (wr_hit[OFS_DATA] && !flash_ce_n);
  cover property ($fell(uart_tx));
  cover property (rd_hit[OFS_RX_STATUS] ##1 reg_rdata[BIT_OVERRUN]);
endmodule : io_port_checker

bind io_port_uart_serial_flash io_port_checker CHK (
  .clock(clock), .arst_n(arst_n), .cpu_reset_n(cpu_reset_n), .periph_addr(periph_addr),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .speed_code(speed_code), .mapper_enabled(mapper_enabled),
  .peek_capture(peek_capture), .peek_value(peek_value), .parallel_pulse(parallel_pulse),
  .uart_tx(uart_tx), .flash_sck(flash_sck), .flash_wp_n(flash_wp_n), .flash_ce_n(flash_ce_n)
);

/* File: testbench/io_port_far_end.sv */
// behavioural far end: remote serial device and serial flash memory
`timescale 1ns/1ns
module io_port_far_end #(
  parameter int BIT_CYCLES = 4
) (
  // system clock
  input wire logic clock,
  // asynchronous serial pins
  input wire logic uart_tx,
  output logic uart_rx,
  // serial flash pins
  input wire logic flash_sck,
  input wire logic flash_do,
  output logic flash_di,
  input wire logic flash_ce_n
);
  logic [7:0] tx_log [4];
  logic [7:0] flash_reply, flash_seen, shift, frame;
  int tx_count = 0;
  int stop_bad = 0;
  initial begin
    uart_rx = 1'b1;
    flash_di = 1'b1;
    flash_reply = 8'h00;
  end
  // one bit time on the receive line, changed just after an edge
  task automatic hold_bit(input logic v);
    uart_rx = v;
    repeat (BIT_CYCLES) @(posedge clock);
    #1;
  endtask : hold_bit
  task automatic send_byte(input logic [7:0] value);
    hold_bit(1'b0);
    for (int i = 0; i < 8; i++) hold_bit(value[i]);
    hold_bit(1'b1);
  endtask : send_byte
  always begin
    @(negedge uart_tx);
    repeat (BIT_CYCLES / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clock);
      frame[i] = uart_tx;
    end
    repeat (2) begin
      repeat (BIT_CYCLES) @(posedge clock);
      if (uart_tx !== 1'b1) stop_bad++;
    end
    tx_log[tx_count % 4] = frame;
    tx_count++;
  end
  // flash answers msb first, next bit after each falling clock
  always @(negedge flash_ce_n) begin
    shift = flash_reply;
    flash_di = shift[7];
  end
  always @(negedge flash_sck) begin
    if (!flash_ce_n) begin
      shift = {shift[6:0], 1'b0};
      flash_di = shift[7];
    end
  end
  // released data line shows the inverse so a stale read cannot pass
  always @(posedge flash_ce_n) flash_di = ~flash_di;
  // outgoing bits taken on the rising clock
  always @(posedge flash_sck) begin
    if (!flash_ce_n) flash_seen = {flash_seen[6:0], flash_do};
  end
endmodule : io_port_far_end

/* File: testbench/io_port_uart_serial_flash_tb_top.sv */
// self-checking bench for the i/o port block
`timescale 1ns/1ns
module io_port_uart_serial_flash_tb_top;
  import io_port_pkg::*;
  typedef struct packed {
    logic [7:0] periph;
    logic [3:0] ofs;
    logic [2:0] speed;
    logic map;
    logic [15:0] exp;
  } row_type;
  localparam int DIV = 3;
  // reads: selection, offset, speed, mapper, expected word
  localparam row_type ROWS [12] = '{
    '{8'hf0, 4'h4, 3'h0, 1'b0, 16'h0000}, '{8'hf0, 4'h4, 3'h1, 1'b0, 16'h0001},
    '{8'hf0, 4'h4, 3'h2, 1'b0, 16'h0002}, '{8'hf0, 4'h4, 3'h3, 1'b0, 16'h0003},
    '{8'hf0, 4'h4, 3'h4, 1'b0, 16'h0004}, '{8'hf0, 4'h4, 3'h5, 1'b0, 16'h0005},
    '{8'hf0, 4'h6, 3'h5, 1'b1, 16'h0001}, '{8'hf0, 4'h6, 3'h0, 1'b0, 16'h0000},
    '{8'hf0, 4'h8, 3'h0, 1'b1, 16'h0000}, '{8'hf0, 4'hc, 3'h0, 1'b1, 16'h0000},
    '{8'hf0, 4'h7, 3'h0, 1'b1, 16'h0000}, '{8'hf1, 4'h4, 3'h5, 1'b1, 16'h0000}};
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic cpu_reset_n = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic mapper_enabled = 1'b0;
  logic peek_capture = 1'b0;
  logic [7:0] periph_addr = 8'hf0;
  logic [3:0] reg_addr = 4'h0;
  logic [2:0] speed_code = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] peek_value = 16'h0000;
  logic [15:0] reg_rdata, got;
  logic parallel_pulse, uart_tx, uart_rx, flash_sck, flash_do, flash_di, flash_wp_n, flash_ce_n;
  int errors = 0;
  int n_compared = 0;

  io_port_uart_serial_flash DUT (
    .clock(clock), .arst_n(arst_n), .cpu_reset_n(cpu_reset_n), .periph_addr(periph_addr),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .speed_code(speed_code), .mapper_enabled(mapper_enabled),
    .peek_capture(peek_capture), .peek_value(peek_value), .parallel_pulse(parallel_pulse),
    .uart_tx(uart_tx), .uart_rx(uart_rx), .flash_sck(flash_sck), .flash_do(flash_do),
    .flash_di(flash_di), .flash_wp_n(flash_wp_n), .flash_ce_n(flash_ce_n));
  io_port_far_end #(.BIT_CYCLES(DIV + 1)) FAR (
    .clock(clock), .uart_tx(uart_tx), .uart_rx(uart_rx), .flash_sck(flash_sck),
    .flash_do(flash_do), .flash_di(flash_di), .flash_ce_n(flash_ce_n));

  // ======
  // 125 MHz system clock
  initial begin
    forever #4 clock = ~clock;
  end
  // inputs always move 1 ns after the rising edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic check_word(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : check_word
  task automatic done_test(input string name);
    $display("test %s finished", name);
  endtask : done_test
  // a gap cycle after each access keeps strobes from being reassigned in one step
  task automatic reg_wr(input logic [3:0] ofs, input logic [15:0] d);
    reg_addr = ofs;
    reg_wdata = d;
    reg_write = 1'b1;
    tick();
    reg_write = 1'b0;
    tick();
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] p, input logic [3:0] ofs, output logic [15:0] d);
    periph_addr = p;
    reg_addr = ofs;
    reg_read = 1'b1;
    tick();
    reg_read = 1'b0;
    d = reg_rdata;
    periph_addr = PERIPH_SELECT;
    tick();
  endtask : reg_rd
  task automatic expect_rd(input logic [3:0] ofs, input logic [15:0] e);
    reg_rd(PERIPH_SELECT, ofs, got);
    check_word(got, e);
  endtask : expect_rd
  // polls the transmit status until both idle and empty, bounded
  task automatic wait_tx_idle();
    int n;
    n = 0;
    got = 16'h0000;
    while (got !== 16'h0011 && n < 300) begin
      reg_rd(PERIPH_SELECT, OFS_TX_STATUS, got);
      n++;
    end
    check_word(got, 16'h0011);
  endtask : wait_tx_idle
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // ======
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    #1;
    arst_n = 1'b1;
    repeat (3) tick();
    reg_wr(OFS_MASTER_RESET, 16'h0001);
    reg_wr(OFS_RATE, 16'(DIV));
    foreach (ROWS[i]) begin
      speed_code = ROWS[i].speed;
      mapper_enabled = ROWS[i].map;
      reg_rd(ROWS[i].periph, ROWS[i].ofs, got);
      check_word(got, ROWS[i].exp);
    end
    done_test("register table");
    // one strobe write, then three back to back
    reg_wr(OFS_STROBE, 16'hffff);
    check_word({15'h0000, parallel_pulse}, 16'h0001);
    reg_addr = OFS_STROBE;
    reg_write = 1'b1;
    repeat (3) tick();
    reg_write = 1'b0;
    tick();
    check_word({15'h0000, parallel_pulse}, 16'h0000);
    done_test("strobe");
    // latch keeps its word after the source moves on
    peek_value = 16'ha5c3;
    peek_capture = 1'b1;
    tick();
    peek_capture = 1'b0;
    peek_value = 16'h0f0f;
    tick();
    expect_rd(OFS_PEEK_DATA, 16'ha5c3);
    done_test("peek");
    // one byte shifting, one held, a third refused
    reg_wr(OFS_CONTROL, 16'h0000);
    reg_wr(OFS_DATA, 16'hff5a);
    tick();
    reg_wr(OFS_DATA, 16'h00c3);
    reg_wr(OFS_DATA, 16'h0077);
    expect_rd(OFS_TX_STATUS, 16'h0000);
    wait_tx_idle();
    repeat (60) tick();
    check_word(16'(FAR.tx_count), 16'h0002);
    check_word({8'h00, FAR.tx_log[0]}, 16'h005a);
    check_word({8'h00, FAR.tx_log[1]}, 16'h00c3);
    check_word(16'(FAR.stop_bad), 16'h0000);
    done_test("transmit");
    // second byte arrives while the first is unread
    FAR.send_byte(8'h3c);
    repeat (8) tick();
    expect_rd(OFS_RX_STATUS, 16'h0001);
    FAR.send_byte(8'h99);
    repeat (8) tick();
    expect_rd(OFS_RX_STATUS, 16'h0011);
    expect_rd(OFS_DATA, 16'h003c);
    expect_rd(OFS_RX_STATUS, 16'h0000);
    done_test("receive");
    // flash exchange, msb first both ways
    FAR.flash_reply = 8'hb4;
    reg_wr(OFS_CONTROL, 16'h0111);
    check_word({14'h0000, flash_wp_n, flash_ce_n}, 16'h0000);
    reg_wr(OFS_DATA, 16'h0096);
    wait_tx_idle();
    check_word({8'h00, FAR.flash_seen}, 16'h0096);
    expect_rd(OFS_DATA, 16'h00b4);
    done_test("flash");
    // processor reset clears the strobe but leaves write-protect alone
    reg_wr(OFS_STROBE, 16'h0000);
    cpu_reset_n = 1'b0;
    repeat (4) tick();
    cpu_reset_n = 1'b1;
    repeat (4) tick();
    check_word({14'h0000, parallel_pulse, flash_wp_n}, 16'h0000);
    reg_wr(OFS_MASTER_RESET, 16'h0000);
    check_word({15'h0000, flash_ce_n}, 16'h0000);
    reg_wr(OFS_MASTER_RESET, 16'h0001);
    check_word({14'h0000, flash_wp_n, flash_ce_n}, 16'h0003);
    done_test("resets");
    report_and_stop();
  end
  // hang guard: the sequence needs well under 3000 cycles
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    report_and_stop();
  end
endmodule : io_port_uart_serial_flash_tb_top
